/* File: rtl/cal_seq.sv */
// calibration sequencer for three two-bank interleaved converter cores
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
module cal_seq (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        cal_trigger_pin,
	input  wire logic [11:0] sample_in,
	output logic [11:0]      sample_out,
	output cal_seq_pkg::core_map_t core_map,
	output logic             irq
);
	localparam int CTRL_W_L = cal_seq_pkg::CTRL_W;
	logic [CTRL_W_L-1:0] ctrl, next_ctrl;
	logic                software_cal_trigger, next_software_cal_trigger;
	logic [31:0]         lp_delay, next_lp_delay;
	logic [31:0]         trim, next_trim;
	logic [11:0]         offset_val, next_offset_val;
	logic [1:0]          irq_stat, next_irq_stat;
	logic [1:0]          irq_mask, next_irq_mask;
	logic [2:0]          trig_sync, next_trig_sync;
	logic                trig_level, next_trig_level;
	logic                soft_prev, next_soft_prev;
	logic                foreground_done_flag, next_foreground_done_flag;
	logic                os_pending, next_os_pending;
	cal_seq_pkg::state_t state, next_state;
	logic [15:0]         count, next_count;
	logic [1:0]          spare, next_spare;
	logic [1:0]          cal_core, next_cal_core;
	logic [1:0]          active_b, next_active_b;
	logic [1:0]          active_a, next_active_a;
	logic                pready_r, next_pready;
	logic [31:0]         prdata_r, next_prdata;
	logic                pslverr_r, next_pslverr;
	logic [11:0]         sample_r, next_sample;
	cal_seq_pkg::core_map_t map_r, next_map;
	logic                irq_r, next_irq;
	logic                trig_sel, bg_en, low_power_bg_enable, low_power_trigger_select, single;
	logic                pin_rise, soft_rise, trig_evt, wr, rd, decode_ok;
	logic [1:0]          evt;

	function automatic logic [2:0] core_bit(input logic [1:0] c);
		core_bit = 3'h1 << c;
	endfunction

	// spare always relieves the core after it in turn, so all three get calibrated
	function automatic logic [1:0] turn_after(input logic [1:0] c);
		turn_after = (c == cal_seq_pkg::CORE_C) ? cal_seq_pkg::CORE_A : c + 2'h1;
	endfunction

	assign trig_sel = ctrl[cal_seq_pkg::CTRL_TRIG_SEL];
	assign bg_en    = ctrl[cal_seq_pkg::CTRL_BG_EN];
	assign low_power_bg_enable    = ctrl[cal_seq_pkg::CTRL_LOW_POWER_BG_ENABLE];
	assign low_power_trigger_select  = ctrl[cal_seq_pkg::CTRL_LOW_POWER_TRIGGER_SELECT];
	assign single   = ctrl[cal_seq_pkg::CTRL_SINGLE];
	assign wr = psel && penable && pwrite && pready_r; // lands on the completing edge only
	assign rd = psel && !penable;
	assign decode_ok = paddr <= cal_seq_pkg::OFF_OFFSET && paddr[1:0] == 2'h0;
	// second and third stages must agree before a change counts
	assign pin_rise  = (trig_sync[2:1] == 2'b11) && !trig_level;
	assign soft_rise = software_cal_trigger && !soft_prev;
	assign trig_evt  = trig_sel ? pin_rise : soft_rise;

	always_comb begin
		next_trig_sync = {trig_sync[1:0], cal_trigger_pin};
		next_trig_level = trig_level;
		if (trig_sync[2] == trig_sync[1]) begin
			next_trig_level = trig_sync[2];
		end
		next_soft_prev = software_cal_trigger;
	end

	// sequencer
	always_comb begin
		next_state = state;
		next_count = count;
		next_spare = spare;
		next_cal_core = cal_core;
		next_active_a = active_a;
		next_active_b = active_b;
		next_foreground_done_flag = foreground_done_flag;
		next_offset_val = offset_val;
		next_os_pending = os_pending;
		evt = 2'h0;
		case (state)
			cal_seq_pkg::ST_IDLE: begin
				if (bg_en && !trig_sel && software_cal_trigger && !low_power_trigger_select) begin
					next_state = low_power_bg_enable ? cal_seq_pkg::ST_SLEEP : cal_seq_pkg::ST_BG;
					next_count = low_power_bg_enable ? lp_delay[cal_seq_pkg::SLEEP_LSB +: 16] : cal_seq_pkg::CAL_COUNT;
				end else if (trig_evt && bg_en && low_power_bg_enable && low_power_trigger_select) begin
					next_state = cal_seq_pkg::ST_WAKE;
					next_count = lp_delay[cal_seq_pkg::WAKE_LSB +: 16];
				end else if (trig_evt && !bg_en) begin
					next_state = cal_seq_pkg::ST_FG;
					next_count = cal_seq_pkg::CAL_COUNT;
					next_foreground_done_flag = 1'b0;
					next_os_pending = ctrl[cal_seq_pkg::CTRL_FG_OS];
				end
			end
			cal_seq_pkg::ST_FG: begin
				// trigger edges are simply not looked at here
				if (count == 16'h0) begin
					next_state = cal_seq_pkg::ST_IDLE;
					next_foreground_done_flag = 1'b1;
					evt[cal_seq_pkg::IRQ_FOREGROUND_DONE_FLAG] = 1'b1;
					if (os_pending) begin
						next_offset_val = cal_seq_pkg::OFFSET_RESULT;
					end
					next_os_pending = 1'b0;
				end else begin
					next_count = count - 16'h1;
				end
			end
			cal_seq_pkg::ST_SLEEP: begin
				if (count == 16'h0) begin
					next_state = cal_seq_pkg::ST_WAKE;
					next_count = lp_delay[cal_seq_pkg::WAKE_LSB +: 16];
				end else begin
					next_count = count - 16'h1;
				end
			end
			cal_seq_pkg::ST_WAKE: begin
				if (count == 16'h0) begin
					next_state = cal_seq_pkg::ST_BG;
					next_count = cal_seq_pkg::CAL_COUNT;
				end else begin
					next_count = count - 16'h1;
				end
			end
			cal_seq_pkg::ST_BG: begin
				if (count == 16'h0) begin
					// freshly calibrated spare replaces the core next in turn
					evt[cal_seq_pkg::IRQ_SWAP] = 1'b1;
					if (active_a == turn_after(spare)) begin
						next_spare = active_a;
						next_active_a = spare;
					end else begin
						next_spare = active_b;
						next_active_b = spare;
					end
					next_cal_core = next_spare;
					if (!bg_en) begin
						next_state = cal_seq_pkg::ST_IDLE;
					end else if (low_power_bg_enable && low_power_trigger_select) begin
						next_state = cal_seq_pkg::ST_IDLE;
					end else if (low_power_bg_enable) begin
						next_state = cal_seq_pkg::ST_SLEEP;
						next_count = lp_delay[cal_seq_pkg::SLEEP_LSB +: 16];
					end else begin
						next_count = cal_seq_pkg::CAL_COUNT;
					end
				end else begin
					next_count = count - 16'h1;
				end
			end
			default: begin
				next_state = cal_seq_pkg::ST_IDLE;
			end
		endcase
	end

	// outputs and core map
	always_comb begin
		next_map.core_in_0 = active_a;
		next_map.core_in_1 = single ? active_a : active_b;
		next_map.core_cal = cal_core;
		// each core powers both its banks; sleeping spare off in low power
		next_map.bank_pwr = core_bit(active_a) | core_bit(active_b);
		if (state == cal_seq_pkg::ST_BG || state == cal_seq_pkg::ST_WAKE || !low_power_bg_enable) begin
			next_map.bank_pwr = next_map.bank_pwr | core_bit(spare);
		end
		if (state == cal_seq_pkg::ST_FG) begin
			next_map.bank_pwr = 3'h7;
			next_map.core_cal = cal_seq_pkg::CORE_C;
		end
		next_sample = (state == cal_seq_pkg::ST_FG) ? cal_seq_pkg::MID_CODE : sample_in;
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	// apb slave
	always_comb begin
		next_ctrl = ctrl;
		next_software_cal_trigger = software_cal_trigger;
		next_lp_delay = lp_delay;
		next_trim = trim;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_pready = psel && !pready_r;
		next_pslverr = psel && !pready_r && !decode_ok;
		next_prdata = prdata_r;
		if (wr && decode_ok) begin
			case (paddr)
				cal_seq_pkg::OFF_CTRL: next_ctrl = pwdata[CTRL_W_L-1:0];
				cal_seq_pkg::OFF_TRIG: next_software_cal_trigger = pwdata[0];
				cal_seq_pkg::OFF_LP_DELAY: next_lp_delay = pwdata;
				cal_seq_pkg::OFF_IRQ_STAT: next_irq_stat = irq_stat & ~pwdata[1:0];
				cal_seq_pkg::OFF_IRQ_MASK: next_irq_mask = pwdata[1:0];
				cal_seq_pkg::OFF_TRIM: next_trim = pwdata;
				default: next_ctrl = ctrl;
			endcase
		end
		next_irq_stat = next_irq_stat | evt; // set wins over clear
		if (rd) begin
			case (paddr)
				cal_seq_pkg::OFF_CTRL: next_prdata = {25'h0, ctrl};
				cal_seq_pkg::OFF_TRIG: next_prdata = {31'h0, software_cal_trigger};
				cal_seq_pkg::OFF_LP_DELAY: next_prdata = lp_delay;
				cal_seq_pkg::OFF_STATUS: next_prdata = {22'h0, spare, active_b, active_a,
					state, foreground_done_flag};
				cal_seq_pkg::OFF_IRQ_STAT: next_prdata = {30'h0, irq_stat};
				cal_seq_pkg::OFF_IRQ_MASK: next_prdata = {30'h0, irq_mask};
				cal_seq_pkg::OFF_TRIM: next_prdata = trim;
				cal_seq_pkg::OFF_OFFSET: next_prdata = {20'h0, offset_val};
				default: next_prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
			software_cal_trigger <= 1'b0;
			lp_delay <= 32'h0;
			trim <= cal_seq_pkg::TRIM_FACTORY;
			offset_val <= 12'h0;
			irq_stat <= 2'h0;
			irq_mask <= 2'h0;
			trig_sync <= 3'h0;
			trig_level <= 1'b0;
			soft_prev <= 1'b0;
			foreground_done_flag <= 1'b0;
			os_pending <= 1'b0;
			// power-up foreground pass starts straight from reset
			state <= cal_seq_pkg::ST_FG;
			count <= cal_seq_pkg::CAL_COUNT;
			spare <= cal_seq_pkg::CORE_C;
			cal_core <= cal_seq_pkg::CORE_C;
			active_a <= cal_seq_pkg::CORE_A;
			active_b <= cal_seq_pkg::CORE_B;
			pready_r <= 1'b0;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
			sample_r <= 12'h0;
			map_r <= '0;
			irq_r <= 1'b0;
		end else if (clk_en) begin
			ctrl <= next_ctrl;
			software_cal_trigger <= next_software_cal_trigger;
			lp_delay <= next_lp_delay;
			trim <= next_trim;
			offset_val <= next_offset_val;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			trig_sync <= next_trig_sync;
			trig_level <= next_trig_level;
			soft_prev <= next_soft_prev;
			foreground_done_flag <= next_foreground_done_flag;
			os_pending <= next_os_pending;
			state <= next_state;
			count <= next_count;
			spare <= next_spare;
			cal_core <= next_cal_core;
			active_a <= next_active_a;
			active_b <= next_active_b;
			pready_r <= next_pready;
			prdata_r <= next_prdata;
			pslverr_r <= next_pslverr;
			sample_r <= next_sample;
			map_r <= next_map;
			irq_r <= next_irq;
		end
	end

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign sample_out = sample_r;
	assign core_map = map_r;
	assign irq = irq_r;

	fg_mid_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state == cal_seq_pkg::ST_FG |=> sample_out == cal_seq_pkg::MID_CODE)
		else $error("mid code missing during foreground calibration");
	foreground_done_flag_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state == cal_seq_pkg::ST_FG && count == 16'h0 |=> foreground_done_flag)
		else $error("done flag not raised");
	fg_ignore_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state == cal_seq_pkg::ST_FG && count != 16'h0 |=> state == cal_seq_pkg::ST_FG)
		else $error("calibration cut short");
	swap_spare_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state == cal_seq_pkg::ST_BG && count == 16'h0 |=> spare != $past(spare))
		else $error("spare not rotated");
	cores_distinct_a: assert property (@(posedge pclk) disable iff (!presetn)
		active_a != active_b && active_a != spare && active_b != spare)
		else $error("core assignment overlap");
	sleep_power_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state == cal_seq_pkg::ST_SLEEP |=> (map_r.bank_pwr & core_bit(spare)) == 3'h0)
		else $error("sleeping spare powered");
	wake_to_bg_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state == cal_seq_pkg::ST_WAKE && count == 16'h0 |=> state == cal_seq_pkg::ST_BG)
		else $error("woken core not calibrated");
	sleep_to_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state == cal_seq_pkg::ST_SLEEP && count == 16'h0 |=> state == cal_seq_pkg::ST_WAKE)
		else $error("sleep delay not followed by wake");
	single_input_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && single |=> map_r.core_in_0 == map_r.core_in_1)
		else $error("single mode cores on different inputs");
endmodule

/* File: rtl/cal_seq_pkg.sv */
// package: register map, fields, states and timing for the calibration sequencer
package cal_seq_pkg;
	localparam logic [11:0] OFF_CTRL      = 12'h000;
	localparam logic [11:0] OFF_TRIG      = 12'h004;
	localparam logic [11:0] OFF_LP_DELAY  = 12'h008;
	localparam logic [11:0] OFF_STATUS    = 12'h00c;
	localparam logic [11:0] OFF_IRQ_STAT  = 12'h010;
	localparam logic [11:0] OFF_IRQ_MASK  = 12'h014;
	localparam logic [11:0] OFF_TRIM      = 12'h018;
	localparam logic [11:0] OFF_OFFSET    = 12'h01c;
	// ctrl fields
	localparam int CTRL_TRIG_SEL = 0;
	localparam int CTRL_BG_EN    = 1;
	localparam int CTRL_LOW_POWER_BG_ENABLE    = 2;
	localparam int CTRL_LOW_POWER_TRIGGER_SELECT  = 3;
	localparam int CTRL_FG_OS    = 4;
	localparam int CTRL_BG_OS    = 5;
	localparam int CTRL_SINGLE   = 6;
	localparam int CTRL_W        = 7;
	// irq fields
	localparam int IRQ_FOREGROUND_DONE_FLAG = 0;
	localparam int IRQ_SWAP    = 1;
	localparam int IRQ_W       = 2;
	// delay fields
	localparam int SLEEP_LSB = 0;
	localparam int WAKE_LSB  = 16;
	localparam int DLY_W     = 16;
	// factory trim: arbitrary neutral value
	localparam logic [31:0] TRIM_FACTORY  = 32'h0000_0800;
	localparam logic [11:0] MID_CODE      = 12'h000;
	// stand-in for a measured offset; arbitrary, but distinct from the reset value
	localparam logic [11:0] OFFSET_RESULT = 12'h01a;
	// calibration pass length
	localparam int CAL_TIME_NS = 40960;
	localparam int CLK_NS      = 40;
	localparam int CAL_CYCLES  = CAL_TIME_NS / CLK_NS;
	localparam logic [15:0] CAL_COUNT = 16'(CAL_CYCLES);
	localparam logic [1:0] CORE_A = 2'h0;
	localparam logic [1:0] CORE_B = 2'h1;
	localparam logic [1:0] CORE_C = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FG    = 3'b001,
		ST_BG    = 3'b010,
		ST_SLEEP = 3'b011,
		ST_WAKE  = 3'b100
	} state_t;
	typedef struct packed {
		logic [1:0] core_in_0;
		logic [1:0] core_in_1;
		logic [1:0] core_cal;
		logic [2:0] bank_pwr;
	} core_map_t;
endpackage

/* File: test/cal_seq_bench.sv */
// self-checking bench for the calibration sequencer
`timescale 1ns/10ps
module cal_seq_bench;
	logic                   pclk;
	logic                   presetn;
	logic                   clk_en;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [11:0]            paddr;
	logic [31:0]            pwdata;
	logic                   pready;
	logic [31:0]            prdata;
	logic                   pslverr;
	logic                   cal_trigger_pin;
	logic [11:0]            sample_in;
	logic [11:0]            sample_out;
	cal_seq_pkg::core_map_t core_map;
	logic                   irq;
	logic [31:0]            q;
	logic                   err;
	logic [11:0]            s;
	int                     failures;
	int                     total_checks;
	int                     cycles;

	cal_seq cal_seq_inst (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .cal_trigger_pin(cal_trigger_pin), .sample_in(sample_in),
		.sample_out(sample_out), .core_map(core_map), .irq(irq)
	);
	cal_sys_ctrl cal_sys_ctrl_inst (
		.pclk(pclk), .cal_trigger_pin(cal_trigger_pin), .sample_in(sample_in)
	);

	always #20 pclk = ~pclk;

	task test_done;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			test_done();
		end
	end

	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one apb transfer; the idle edge at the end keeps strobes from being re-driven in one step
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) failures++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// reads until the masked field matches, bounded by maxn reads
	task poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v, input int maxn);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((q & m) !== v && n < maxn);
		check("poll", v, q & m);
	endtask

	task fresh_reset;
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		check("midcode", {20'h0, cal_seq_pkg::MID_CODE}, {20'h0, sample_out});
		check("core a in", 32'(cal_seq_pkg::CORE_A), 32'(core_map.core_in_0));
		check("core b in", 32'(cal_seq_pkg::CORE_B), 32'(core_map.core_in_1));
		poll(cal_seq_pkg::OFF_STATUS, 32'h1, 32'h1, 600);
	endtask

	task st(input cal_seq_pkg::state_t x, input int maxn);
		poll(cal_seq_pkg::OFF_STATUS, 32'he, {28'h0, x, 1'b0}, maxn);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		failures = 0;
		total_checks = 0;
		cycles = 0;
		@(posedge pclk);
		fresh_reset();
		// interrupt: sticky, masked, then cleared by writing one
		poll(cal_seq_pkg::OFF_IRQ_STAT, 32'h1, 32'h1, 1);
		check("irq masked", 32'h0, {31'h0, irq});
		wr(cal_seq_pkg::OFF_IRQ_MASK, 32'h1);
		check("irq on", 32'h1, {31'h0, irq});
		wr(cal_seq_pkg::OFF_IRQ_STAT, 32'h1);
		check("irq off", 32'h0, {31'h0, irq});
		// trim factory value then overwrite
		poll(cal_seq_pkg::OFF_TRIM, 32'hffffffff, cal_seq_pkg::TRIM_FACTORY, 1);
		wr(cal_seq_pkg::OFF_TRIM, 32'h0000_0a5c);
		poll(cal_seq_pkg::OFF_TRIM, 32'hffffffff, 32'h0000_0a5c, 1);
		// single channel: active_a drives both inputs; map is registered, so wait an edge
		wr(cal_seq_pkg::OFF_CTRL, 32'h40);
		@(posedge pclk);
		check("single in", 32'(cal_seq_pkg::CORE_A), 32'(core_map.core_in_1));
		// unmapped offset is refused
		apb(1'b0, 12'h020, 32'h0);
		check("slverr", 32'h1, {31'h0, err});
		check("unmapped data", 32'h0, q);
		// idle: data passes with one cycle of delay
		@(posedge pclk);
		s = sample_in;
		@(posedge pclk);
		check("pass", {20'h0, s}, {20'h0, sample_out});
		// enable low freezes every register, data path included
		clk_en <= 1'b0;
		@(posedge pclk);
		s = sample_out;
		repeat (8) @(posedge pclk);
		check("frozen", {20'h0, s}, {20'h0, sample_out});
		clk_en <= 1'b1;
		// pin trigger; a second pulse mid-run must be ignored
		wr(cal_seq_pkg::OFF_CTRL, 32'h1);
		cal_sys_ctrl_inst.pulse_pin(4);
		st(cal_seq_pkg::ST_FG, 5);
		check("fg midcode", 32'h0, {20'h0, sample_out});
		cal_sys_ctrl_inst.pulse_pin(4);
		st(cal_seq_pkg::ST_IDLE, 600);
		repeat (20) @(posedge pclk);
		st(cal_seq_pkg::ST_IDLE, 1);
		poll(cal_seq_pkg::OFF_OFFSET, 32'hfff, 32'h0, 1);
		// software trigger with one-shot offset calibration armed first
		wr(cal_seq_pkg::OFF_CTRL, 32'h10);
		wr(cal_seq_pkg::OFF_TRIG, 32'h1);
		st(cal_seq_pkg::ST_FG, 5);
		poll(cal_seq_pkg::OFF_STATUS, 32'h1, 32'h1, 600);
		poll(cal_seq_pkg::OFF_OFFSET, 32'hfff, {20'h0, cal_seq_pkg::OFFSET_RESULT}, 1);
		wr(cal_seq_pkg::OFF_TRIG, 32'h0);
		// background: spare rotates in, data keeps flowing
		wr(cal_seq_pkg::OFF_IRQ_STAT, 32'h3);
		wr(cal_seq_pkg::OFF_CTRL, 32'h2);
		wr(cal_seq_pkg::OFF_TRIG, 32'h1);
		st(cal_seq_pkg::ST_BG, 5);
		apb(1'b0, cal_seq_pkg::OFF_STATUS, 32'h0);
		s = {10'h0, q[9:8]};
		check("spare c", 32'(cal_seq_pkg::CORE_C), {30'h0, q[9:8]});
		@(posedge pclk);
		check("bg no midcode", 32'h0, {31'h0, sample_out === cal_seq_pkg::MID_CODE});
		poll(cal_seq_pkg::OFF_IRQ_STAT, 32'h2, 32'h2, 900);
		apb(1'b0, cal_seq_pkg::OFF_STATUS, 32'h0);
		check("spare moved", 32'h0, {31'h0, q[9:8] === s[1:0]});
		wr(cal_seq_pkg::OFF_TRIG, 32'h0);
		// low-power background: spare sleeps then wakes
		fresh_reset();
		wr(cal_seq_pkg::OFF_LP_DELAY, {16'h000a, 16'h0014});
		wr(cal_seq_pkg::OFF_CTRL, 32'h6);
		wr(cal_seq_pkg::OFF_TRIG, 32'h1);
		st(cal_seq_pkg::ST_SLEEP, 1500);
		s = {10'h0, q[9:8]};
		check("spare off", 32'h0, {31'h0, core_map.bank_pwr[s[1:0]]});
		st(cal_seq_pkg::ST_WAKE, 10);
		check("spare on", 32'h1, {31'h0, core_map.bank_pwr[s[1:0]]});
		// user-driven switching: no sleep, a fresh software edge wakes the spare
		wr(cal_seq_pkg::OFF_CTRL, 32'he);
		wr(cal_seq_pkg::OFF_TRIG, 32'h0);
		st(cal_seq_pkg::ST_IDLE, 700);
		wr(cal_seq_pkg::OFF_TRIG, 32'h1);
		st(cal_seq_pkg::ST_WAKE, 5);
		test_done();
	end
endmodule

/* File: test/cal_sys_ctrl.sv */
// system controller model: trigger pin and analog input stimulus
`timescale 1ns/10ps
module cal_sys_ctrl (
	input  wire logic   pclk,
	output logic        cal_trigger_pin,
	output logic [11:0] sample_in
);
	initial begin
		cal_trigger_pin = 1'b0;
		sample_in = 12'h123;
	end
	// stepping pattern keeps input energy away from dc
	always @(posedge pclk) begin
		sample_in <= sample_in + 12'h155;
	end
	// level held for several edges so the synchroniser cannot miss it
	task pulse_pin(input int hi);
		cal_trigger_pin <= 1'b1;
		repeat (hi) @(posedge pclk);
		cal_trigger_pin <= 1'b0;
		@(posedge pclk);
	endtask
endmodule
